/* File: hwm_consts.vh */
// register offsets, resets and field positions for the monitor register bank
`ifndef HWM_CONSTS_VH
`define HWM_CONSTS_VH
// bank 0 indexes; byte address is {bank, index[6:0], 2'b00}, bank in bits 11:9
`define HWM_BANK_MSB          11
`define HWM_IDX_SYS_FAN_OUT   8'h01
`define HWM_IDX_CPU_FAN_OUT   8'h03
`define HWM_IDX_FAN_CFG_ONE   8'h04
`define HWM_IDX_SYS_TARGET    8'h05
`define HWM_IDX_CPU_TARGET    8'h06
`define HWM_IDX_BAT_CTRL      8'h5D
// bank 2
`define HWM_IDX_AUX_OVT_HIGH  8'h55
`define HWM_IDX_AUX_OVT_LOW   8'h56
// bank 4
`define HWM_IDX_INT_STAT_3    8'h50
`define HWM_IDX_SMI_MASK_3    8'h51
`define HWM_IDX_BEEP_CTRL_3   8'h53
`define HWM_IDX_SYS_OFFSET    8'h54
`define HWM_IDX_CPU_OFFSET    8'h55
`define HWM_IDX_AUX_OFFSET    8'h56
`define HWM_IDX_LIVE_STAT_1   8'h59
`define HWM_IDX_LIVE_STAT_2   8'h5A
`define HWM_IDX_LIVE_STAT_3   8'h5B
// bank 5
`define HWM_IDX_SB_READING    8'h50
`define HWM_IDX_BAT_READING   8'h51
`define HWM_IDX_SB_HIGH       8'h54
`define HWM_IDX_SB_LOW        8'h55
`define HWM_IDX_BAT_HIGH      8'h56
`define HWM_IDX_BAT_LOW       8'h57
// banks
`define HWM_BANK_0            3'h0
`define HWM_BANK_2            3'h2
`define HWM_BANK_4            3'h4
`define HWM_BANK_5            3'h5
// reset values
`define HWM_RST_FAN_OUT       8'hFF
`define HWM_RST_SMI_MASK      8'hFF
`define HWM_RST_AUX_OVT_HIGH  8'h50
`define HWM_RST_ZERO          8'h00
`define HWM_RST_SB_HIGH       8'hFF
`define HWM_RST_BAT_HIGH      8'hFF
// fields
`define HWM_STAT3_AUX_WARN    2
`define HWM_STAT3_BAT         1
`define HWM_STAT3_SB          0
`define HWM_MASK3_WMASK       8'h13
`define HWM_BEEP_FORCE        5
`define HWM_BEEP3_WMASK       8'h23
`define HWM_MODE_MANUAL       2'b00
`define HWM_MODE_THERMAL      2'b01
`define HWM_MODE_SPEED        2'b10
// bus answers
`define HWM_RESP_OKAY         2'b00
`define HWM_RESP_SLVERR       2'b10
`endif

/* File: hwm_status_fan_regs.v */
// register bank of the hardware monitor: status, masks, beep, offsets, fan control
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "hwm_consts.vh"
module hwm_status_fan_regs #(
  parameter ADDR_W = 12
) (
  // clock and reset
  input  wire              aclk,
  input  wire              aresetn,
  // axi4-lite write address
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]        s_axi_awprot,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  // axi4-lite read address
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]        s_axi_arprot,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  // axi4-lite read data
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // conversion results, valid while sample_strobe is high
  input  wire              sample_strobe,
  input  wire [7:0]        standby_five_volt_value,
  input  wire [7:0]        battery_value,
  input  wire [8:0]        system_temp_input,
  input  wire [8:0]        processor_temp_input,
  input  wire [8:0]        auxiliary_temp_input,
  // hysteresis and over-temperature limits, 9 bits in half degrees
  input  wire [8:0]        system_temp_overlimit,
  input  wire [8:0]        system_temp_hyst,
  input  wire [8:0]        processor_temp_overlimit,
  input  wire [8:0]        processor_temp_hyst,
  input  wire [8:0]        auxiliary_temp_hyst,
  // comparator results from the conversion logic
  input  wire              processor_tach_input,
  input  wire              system_tach_input,
  input  wire              analog_supply_out,
  input  wire              voltage_input_one_out,
  input  wire              voltage_input_zero_out,
  input  wire              core_voltage_out,
  input  wire              voltage_input_two_out,
  // cruise loop warnings and chassis intrusion
  input  wire              processor_fan_warn,
  input  wire              system_fan_warn,
  input  wire              auxiliary_fan_warn,
  input  wire              intrusion_detect,
  // outputs to the fans and the system
  output reg  [3:0]        system_fan_drive,
  output reg  [3:0]        processor_fan_drive,
  output reg  [1:0]        system_fan_mode,
  output reg  [1:0]        processor_fan_mode,
  output reg  [6:0]        system_target_temp,
  output reg  [7:0]        system_target_speed,
  output reg  [6:0]        processor_target_temp,
  output reg  [7:0]        processor_target_speed,
  output reg  [8:0]        auxiliary_overtemp_limit,
  output reg               battery_monitor_enable,
  output reg               beep_out,
  output reg               system_mgmt_interrupt_n
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg [7:0] fan_out_sys, fan_out_cpu, fan_cfg_one, target_sys, target_cpu;
  reg [7:0] bat_ctrl, aux_ovt_high, aux_ovt_low;
  reg [7:0] int_stat3, smi_mask3, beep_ctrl3;
  reg [7:0] sys_offset, cpu_offset, aux_offset;
  reg [7:0] sb_reading, bat_reading, sb_high, sb_low, bat_high, bat_low;
  reg       sys_temp_stat, cpu_temp_stat, aux_temp_stat, intrusion_latched;
  reg       sb_out, bat_out;
  reg [8:0] aux_reading_temp, sys_reading_temp, cpu_reading_temp;
  // add an 8-bit offset to a 9-bit half-degree reading, offset in whole degrees
  function [8:0] add_offset;
    input [8:0] temp;
    input [7:0] offs;
    begin
      add_offset = temp + {offs, 1'b0};
    end
  endfunction
  // hysteretic over-temperature status
  function next_temp_stat;
    input       cur;
    input [8:0] temp;
    input [8:0] over;
    input [8:0] hyst;
    begin
      if (temp > over)
        next_temp_stat = 1'b1;
      else if (temp < hyst)
        next_temp_stat = 1'b0;
      else
        next_temp_stat = cur;
    end
  endfunction
  function out_of_range;
    input [7:0] val;
    input [7:0] hi;
    input [7:0] lo;
    begin
      out_of_range = (val > hi) || (val < lo);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite handshake
  reg              aw_held, w_held;
  reg [ADDR_W-1:0] aw_addr;
  reg [31:0]       w_data;
  reg [3:0]        w_strb;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire              aw_now = aw_held || s_axi_awvalid;
  wire              w_now  = w_held || s_axi_wvalid;
  wire              do_wr  = aw_now && w_now && !s_axi_bvalid;
  wire [ADDR_W-1:0] wa     = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0]       wd     = w_held ? w_data : s_axi_wdata;
  wire [3:0]        ws     = w_held ? w_strb : s_axi_wstrb;
  wire [2:0]        wbank  = wa[`HWM_BANK_MSB:`HWM_BANK_MSB-2];
  wire [7:0]        widx   = {1'b0, wa[`HWM_BANK_MSB-3:2]};
  wire              wlane  = ws[0];
  wire [7:0]        wb     = wd[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // write decode
  reg wr_hit;
  always @* begin
    wr_hit = 1'b1;
    if (wbank == `HWM_BANK_0 && widx == `HWM_IDX_SYS_FAN_OUT) wr_hit = 1'b1;
    else if (wbank == `HWM_BANK_0 && widx == `HWM_IDX_CPU_FAN_OUT) wr_hit = 1'b1;
    else if (wbank == `HWM_BANK_0 && widx == `HWM_IDX_FAN_CFG_ONE) wr_hit = 1'b1;
    else if (wbank == `HWM_BANK_0 && widx == `HWM_IDX_SYS_TARGET) wr_hit = 1'b1;
    else if (wbank == `HWM_BANK_0 && widx == `HWM_IDX_CPU_TARGET) wr_hit = 1'b1;
    else if (wbank == `HWM_BANK_0 && widx == `HWM_IDX_BAT_CTRL) wr_hit = 1'b1;
    else if (wbank == `HWM_BANK_2 && widx == `HWM_IDX_AUX_OVT_HIGH) wr_hit = 1'b1;
    else if (wbank == `HWM_BANK_2 && widx == `HWM_IDX_AUX_OVT_LOW) wr_hit = 1'b1;
    else if (wbank == `HWM_BANK_4 && widx == `HWM_IDX_SMI_MASK_3) wr_hit = 1'b1;
    else if (wbank == `HWM_BANK_4 && widx == `HWM_IDX_BEEP_CTRL_3) wr_hit = 1'b1;
    else if (wbank == `HWM_BANK_4 && widx == `HWM_IDX_SYS_OFFSET) wr_hit = 1'b1;
    else if (wbank == `HWM_BANK_4 && widx == `HWM_IDX_CPU_OFFSET) wr_hit = 1'b1;
    else if (wbank == `HWM_BANK_4 && widx == `HWM_IDX_AUX_OFFSET) wr_hit = 1'b1;
    else if (wbank == `HWM_BANK_5 && widx == `HWM_IDX_SB_HIGH) wr_hit = 1'b1;
    else if (wbank == `HWM_BANK_5 && widx == `HWM_IDX_SB_LOW) wr_hit = 1'b1;
    else if (wbank == `HWM_BANK_5 && widx == `HWM_IDX_BAT_HIGH) wr_hit = 1'b1;
    else if (wbank == `HWM_BANK_5 && widx == `HWM_IDX_BAT_LOW) wr_hit = 1'b1;
    else wr_hit = 1'b0;
  end

  wire wr_en = do_wr && wlane;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= {ADDR_W{1'b0}};
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `HWM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready && !do_wr) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !do_wr) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `HWM_RESP_OKAY : `HWM_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software-written registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      fan_out_sys  <= `HWM_RST_FAN_OUT;
      fan_out_cpu  <= `HWM_RST_FAN_OUT;
      fan_cfg_one  <= `HWM_RST_ZERO;
      target_sys   <= `HWM_RST_ZERO;
      target_cpu   <= `HWM_RST_ZERO;
      bat_ctrl     <= `HWM_RST_ZERO;
      aux_ovt_high <= `HWM_RST_AUX_OVT_HIGH;
      aux_ovt_low  <= `HWM_RST_ZERO;
      smi_mask3    <= `HWM_RST_SMI_MASK;
      beep_ctrl3   <= `HWM_RST_ZERO;
      sys_offset   <= `HWM_RST_ZERO;
      cpu_offset   <= `HWM_RST_ZERO;
      aux_offset   <= `HWM_RST_ZERO;
      sb_high      <= `HWM_RST_SB_HIGH;
      sb_low       <= `HWM_RST_ZERO;
      bat_high     <= `HWM_RST_BAT_HIGH;
      bat_low      <= `HWM_RST_ZERO;
    end else if (wr_en) begin
      if (wbank == `HWM_BANK_0 && widx == `HWM_IDX_SYS_FAN_OUT) fan_out_sys <= wb;
      else if (wbank == `HWM_BANK_0 && widx == `HWM_IDX_CPU_FAN_OUT) fan_out_cpu <= wb;
      else if (wbank == `HWM_BANK_0 && widx == `HWM_IDX_FAN_CFG_ONE) fan_cfg_one <= wb;
      else if (wbank == `HWM_BANK_0 && widx == `HWM_IDX_SYS_TARGET) target_sys <= wb;
      else if (wbank == `HWM_BANK_0 && widx == `HWM_IDX_CPU_TARGET) target_cpu <= wb;
      else if (wbank == `HWM_BANK_0 && widx == `HWM_IDX_BAT_CTRL) bat_ctrl <= wb;
      else if (wbank == `HWM_BANK_2 && widx == `HWM_IDX_AUX_OVT_HIGH) aux_ovt_high <= wb;
      else if (wbank == `HWM_BANK_2 && widx == `HWM_IDX_AUX_OVT_LOW)
        aux_ovt_low <= {wb[7], 7'h00};
      else if (wbank == `HWM_BANK_4 && widx == `HWM_IDX_SMI_MASK_3)
        smi_mask3 <= (wb & `HWM_MASK3_WMASK) | ~`HWM_MASK3_WMASK;
      else if (wbank == `HWM_BANK_4 && widx == `HWM_IDX_BEEP_CTRL_3)
        beep_ctrl3 <= wb & `HWM_BEEP3_WMASK;
      else if (wbank == `HWM_BANK_4 && widx == `HWM_IDX_SYS_OFFSET) sys_offset <= wb;
      else if (wbank == `HWM_BANK_4 && widx == `HWM_IDX_CPU_OFFSET) cpu_offset <= wb;
      else if (wbank == `HWM_BANK_4 && widx == `HWM_IDX_AUX_OFFSET) aux_offset <= wb;
      else if (wbank == `HWM_BANK_5 && widx == `HWM_IDX_SB_HIGH) sb_high <= wb;
      else if (wbank == `HWM_BANK_5 && widx == `HWM_IDX_SB_LOW) sb_low <= wb;
      else if (wbank == `HWM_BANK_5 && widx == `HWM_IDX_BAT_HIGH) bat_high <= wb;
      else if (wbank == `HWM_BANK_5 && widx == `HWM_IDX_BAT_LOW) bat_low <= wb;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // monitored values and status
  wire sb_viol  = out_of_range(sb_reading, sb_high, sb_low);
  wire bat_viol = bat_ctrl[0] && out_of_range(bat_reading, bat_high, bat_low);

  always @(posedge aclk) begin
    if (!aresetn) begin
      sb_reading        <= `HWM_RST_ZERO;
      bat_reading       <= `HWM_RST_ZERO;
      sys_temp_stat     <= 1'b0;
      cpu_temp_stat     <= 1'b0;
      aux_temp_stat     <= 1'b0;
      aux_reading_temp  <= 9'h000;
      sys_reading_temp  <= 9'h000;
      cpu_reading_temp  <= 9'h000;
      intrusion_latched <= 1'b0;
      sb_out            <= 1'b0;
      bat_out           <= 1'b0;
      int_stat3         <= `HWM_RST_ZERO;
    end else begin
      if (sample_strobe) begin
        sb_reading       <= standby_five_volt_value;
        aux_reading_temp <= auxiliary_temp_input;
        sys_reading_temp <= system_temp_input;
        cpu_reading_temp <= processor_temp_input;
        if (bat_ctrl[0])
          bat_reading <= battery_value;
        sys_temp_stat <= next_temp_stat(sys_temp_stat, system_temp_input,
                                        system_temp_overlimit, system_temp_hyst);
        cpu_temp_stat <= next_temp_stat(cpu_temp_stat, processor_temp_input,
                                        processor_temp_overlimit, processor_temp_hyst);
        aux_temp_stat <= next_temp_stat(aux_temp_stat, auxiliary_temp_input,
                                        auxiliary_overtemp_limit, auxiliary_temp_hyst);
      end
      if (intrusion_detect)
        intrusion_latched <= 1'b1;
      sb_out  <= sb_viol;
      bat_out <= bat_viol;
      // sticky events; no software clear is defined, reset clears them
      if (auxiliary_fan_warn)
        int_stat3[`HWM_STAT3_AUX_WARN] <= 1'b1;
      if (bat_viol)
        int_stat3[`HWM_STAT3_BAT] <= 1'b1;
      if (sb_viol)
        int_stat3[`HWM_STAT3_SB] <= 1'b1;
    end
  end

  wire [7:0] live1 = {processor_tach_input, system_tach_input,
                      cpu_temp_stat, sys_temp_stat,
                      analog_supply_out, voltage_input_one_out,
                      voltage_input_zero_out, core_voltage_out};
  wire [7:0] live2 = {processor_fan_warn, system_fan_warn,
                      aux_temp_stat, intrusion_latched,
                      processor_tach_input, 2'b00, voltage_input_two_out};
  wire [7:0] live3 = {5'b00000, auxiliary_fan_warn, bat_out, sb_out};

  wire [8:0] sys_temp_read = add_offset(sys_reading_temp, sys_offset);
  wire [8:0] cpu_temp_read = add_offset(cpu_reading_temp, cpu_offset);
  wire [8:0] aux_temp_read = add_offset(aux_reading_temp, aux_offset);

  ////////////////////////////////////////////////////////////////////////////
  // outputs to fans, beep and interrupt
  always @(posedge aclk) begin
    if (!aresetn) begin
      system_fan_drive         <= 4'hF;
      processor_fan_drive      <= 4'hF;
      system_fan_mode          <= `HWM_MODE_MANUAL;
      processor_fan_mode       <= `HWM_MODE_MANUAL;
      system_target_temp       <= 7'h00;
      system_target_speed      <= 8'h00;
      processor_target_temp    <= 7'h00;
      processor_target_speed   <= 8'h00;
      auxiliary_overtemp_limit <= {`HWM_RST_AUX_OVT_HIGH, 1'b0};
      battery_monitor_enable   <= 1'b0;
      beep_out                 <= 1'b0;
      system_mgmt_interrupt_n  <= 1'b1;
    end else begin
      system_fan_drive    <= fan_out_sys[7:4];
      processor_fan_drive <= fan_out_cpu[7:4];
      // reserved code 11 falls back to manual
      processor_fan_mode  <= (fan_cfg_one[5:4] == 2'b11) ?
                             `HWM_MODE_MANUAL : fan_cfg_one[5:4];
      system_fan_mode     <= (fan_cfg_one[3:2] == 2'b11) ?
                             `HWM_MODE_MANUAL : fan_cfg_one[3:2];
      system_target_temp     <= target_sys[6:0];
      system_target_speed    <= target_sys;
      processor_target_temp  <= target_cpu[6:0];
      processor_target_speed <= target_cpu;
      auxiliary_overtemp_limit <= {aux_ovt_high, aux_ovt_low[7]};
      battery_monitor_enable <= bat_ctrl[0];
      beep_out <= beep_ctrl3[`HWM_BEEP_FORCE] ||
                  (beep_ctrl3[1] && bat_out) ||
                  (beep_ctrl3[0] && sb_out);
      system_mgmt_interrupt_n <= ~|(int_stat3[2:0] & ~{smi_mask3[4], smi_mask3[1:0]});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path
  wire [2:0] rbank = s_axi_araddr[`HWM_BANK_MSB:`HWM_BANK_MSB-2];
  wire [7:0] ridx  = {1'b0, s_axi_araddr[`HWM_BANK_MSB-3:2]};
  reg  [7:0] rd_val;
  reg        rd_hit;
  always @* begin
    rd_hit = 1'b1;
    rd_val = 8'h00;
    if (rbank == `HWM_BANK_0 && ridx == `HWM_IDX_SYS_FAN_OUT) rd_val = fan_out_sys;
    else if (rbank == `HWM_BANK_0 && ridx == `HWM_IDX_CPU_FAN_OUT) rd_val = fan_out_cpu;
    else if (rbank == `HWM_BANK_0 && ridx == `HWM_IDX_FAN_CFG_ONE) rd_val = fan_cfg_one;
    else if (rbank == `HWM_BANK_0 && ridx == `HWM_IDX_SYS_TARGET) rd_val = target_sys;
    else if (rbank == `HWM_BANK_0 && ridx == `HWM_IDX_CPU_TARGET) rd_val = target_cpu;
    else if (rbank == `HWM_BANK_0 && ridx == `HWM_IDX_BAT_CTRL) rd_val = bat_ctrl;
    else if (rbank == `HWM_BANK_2 && ridx == `HWM_IDX_AUX_OVT_HIGH) rd_val = aux_ovt_high;
    else if (rbank == `HWM_BANK_2 && ridx == `HWM_IDX_AUX_OVT_LOW) rd_val = aux_ovt_low;
    else if (rbank == `HWM_BANK_4 && ridx == `HWM_IDX_INT_STAT_3) rd_val = int_stat3;
    else if (rbank == `HWM_BANK_4 && ridx == `HWM_IDX_SMI_MASK_3) rd_val = smi_mask3;
    else if (rbank == `HWM_BANK_4 && ridx == `HWM_IDX_BEEP_CTRL_3) rd_val = beep_ctrl3;
    else if (rbank == `HWM_BANK_4 && ridx == `HWM_IDX_SYS_OFFSET) rd_val = sys_offset;
    else if (rbank == `HWM_BANK_4 && ridx == `HWM_IDX_CPU_OFFSET) rd_val = cpu_offset;
    else if (rbank == `HWM_BANK_4 && ridx == `HWM_IDX_AUX_OFFSET) rd_val = aux_offset;
    else if (rbank == `HWM_BANK_4 && ridx == `HWM_IDX_LIVE_STAT_1) rd_val = live1;
    else if (rbank == `HWM_BANK_4 && ridx == `HWM_IDX_LIVE_STAT_2) rd_val = live2;
    else if (rbank == `HWM_BANK_4 && ridx == `HWM_IDX_LIVE_STAT_3) rd_val = live3;
    else if (rbank == `HWM_BANK_5 && ridx == `HWM_IDX_SB_READING) rd_val = sb_reading;
    else if (rbank == `HWM_BANK_5 && ridx == `HWM_IDX_BAT_READING) rd_val = bat_reading;
    else if (rbank == `HWM_BANK_5 && ridx == `HWM_IDX_SB_HIGH) rd_val = sb_high;
    else if (rbank == `HWM_BANK_5 && ridx == `HWM_IDX_SB_LOW) rd_val = sb_low;
    else if (rbank == `HWM_BANK_5 && ridx == `HWM_IDX_BAT_HIGH) rd_val = bat_high;
    else if (rbank == `HWM_BANK_5 && ridx == `HWM_IDX_BAT_LOW) rd_val = bat_low;
    else rd_hit = 1'b0;
  end

  // offset temperature readings sit in bank 6 (high byte, low byte) per channel
  reg [7:0] temp_val;
  reg       temp_hit;
  always @* begin
    temp_hit = 1'b1;
    temp_val = 8'h00;
    if (rbank == 3'h6 && ridx == 8'h00) temp_val = sys_temp_read[8:1];
    else if (rbank == 3'h6 && ridx == 8'h01) temp_val = {sys_temp_read[0], 7'h00};
    else if (rbank == 3'h6 && ridx == 8'h02) temp_val = cpu_temp_read[8:1];
    else if (rbank == 3'h6 && ridx == 8'h03) temp_val = {cpu_temp_read[0], 7'h00};
    else if (rbank == 3'h6 && ridx == 8'h04) temp_val = aux_temp_read[8:1];
    else if (rbank == 3'h6 && ridx == 8'h05) temp_val = {aux_temp_read[0], 7'h00};
    else temp_hit = 1'b0;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `HWM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_val | temp_val};
      s_axi_rresp  <= (rd_hit || temp_hit) ? `HWM_RESP_OKAY : `HWM_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // hwm_status_fan_regs

/* File: hwm_props.sv */
// port assertions of the monitor register bank
`timescale 1ns/1ns
module hwm_props (
  input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
  input wire logic s_axi_arready, s_axi_rvalid, s_axi_rready, beep_out,
  input wire logic system_mgmt_interrupt_n,
  input wire logic [1:0] s_axi_bresp, system_fan_mode, processor_fan_mode,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [3:0] system_fan_drive, processor_fan_drive,
  input wire logic [8:0] auxiliary_overtemp_limit
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_fan_reset: assert property (!$past(aresetn) |-> system_fan_drive == 4'hF
    && processor_fan_drive == 4'hF && !beep_out && system_mgmt_interrupt_n) else $error("reset");
  a_limit_reset: assert property (!$past(aresetn)
    |-> auxiliary_overtemp_limit == 9'h0A0) else $error("aux limit");
  a_mode_legal: assert property (system_fan_mode != 2'b11
    && processor_fan_mode != 2'b11) else $error("mode");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> s_axi_bvalid) else $error("no bvalid");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no rvalid");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata");
  a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("busy");
endmodule // hwm_props
bind hwm_status_fan_regs hwm_props u_props (.*);

/* File: hwm_far.sv */
// far-side model: conversion results and temperature limits
`timescale 1ns/1ns
module hwm_far (
  input  wire logic  aclk,
  output logic       sample_strobe = 0,
  output logic [7:0] standby_five_volt_value = 0, battery_value = 0,
  output logic [8:0] system_temp_input = 0, processor_temp_input = 0, auxiliary_temp_input = 0,
  output logic [8:0] system_temp_overlimit = 9'h060, processor_temp_overlimit = 9'h1FF,
  output logic [8:0] system_temp_hyst = 9'h050, processor_temp_hyst = 9'h050,
  output logic [8:0] auxiliary_temp_hyst = 9'h050
);
  // values are inverted once the strobe is gone
  task automatic conv(input [7:0] sb, input [7:0] bat, input [8:0] tv);
    @(posedge aclk);
    {standby_five_volt_value, battery_value, sample_strobe} <= {sb, bat, 1'b1};
    {system_temp_input, processor_temp_input, auxiliary_temp_input} <= {3{tv}};
    @(posedge aclk);
    {standby_five_volt_value, battery_value, sample_strobe} <= {~sb, ~bat, 1'b0};
    {system_temp_input, processor_temp_input, auxiliary_temp_input} <= {3{~tv}};
  endtask
endmodule // hwm_far

/* File: tb_hwm_status_fan_regs.sv */
// self-checking bench of the monitor register bank
`timescale 1ns/1ns
module tb_hwm_status_fan_regs;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, sample_strobe, battery_monitor_enable, beep_out;
  logic processor_tach_input = 0, system_tach_input = 0, analog_supply_out = 0;
  logic voltage_input_one_out = 0, voltage_input_zero_out = 0, core_voltage_out = 0;
  logic voltage_input_two_out = 0, processor_fan_warn = 0, system_fan_warn = 0;
  logic auxiliary_fan_warn = 0, intrusion_detect = 0, system_mgmt_interrupt_n;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0, t;
  logic [3:0] s_axi_wstrb = 4'h1, system_fan_drive, processor_fan_drive;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, system_fan_mode, processor_fan_mode;
  logic [7:0] standby_five_volt_value, battery_value, system_target_speed, processor_target_speed;
  logic [6:0] system_target_temp, processor_target_temp;
  logic [8:0] system_temp_input, processor_temp_input, auxiliary_temp_input, system_temp_hyst;
  logic [8:0] system_temp_overlimit, processor_temp_overlimit, processor_temp_hyst;
  logic [8:0] auxiliary_temp_hyst, auxiliary_overtemp_limit;
  int fails = 0, tests_run = 0, cyc = 0;
  always #50 aclk = ~aclk;
  hwm_status_fan_regs DUT (.*);
  hwm_far far (.*);
  ////////////////////////////////////////////////////////////////////////////////
  // one axi4-lite transfer; ends at the falling edge after the answer
  task automatic xfer(input w, input [11:0] a, input [7:0] d);
    @(posedge aclk);
    if (w) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <=
      {a, 24'h0, d, 3'h7};
    else {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do begin
      @(negedge aclk);
      t = w ? {s_axi_awready, s_axi_wready, s_axi_bvalid} : {s_axi_arready, 1'b0, s_axi_rvalid};
      {rsp, rd} = w ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
      @(posedge aclk);
      if (t[2]) {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
      if (t[1]) s_axi_wvalid <= 0;
      if (t[0]) {s_axi_bready, s_axi_rready} <= 2'h0;
    end while (!t[0]);
    @(negedge aclk);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin fails++; $display("BAD %s exp %h got %h", n, e, s); end
  endtask
  task automatic rdchk(input [2:0] b, input [7:0] i, input [7:0] e);
    xfer(0, {b, i[6:0], 2'b00}, 0);
    chk("read", {24'h0, e}, rd);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge aclk) if (++cyc == 3000) begin fails++; stop_test; end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    rdchk(0, 8'h01, 8'hFF);
    rdchk(4, 8'h51, 8'hFF);
    rdchk(2, 8'h55, 8'h50);
    xfer(1, 12'h554, 8'h5A);
    xfer(1, 12'h558, 8'hFF);
    chk("aux limit", 9'h0B5, auxiliary_overtemp_limit);
    rdchk(2, 8'h56, 8'h80);
    xfer(1, 12'h004, 8'hA7);
    xfer(1, 12'h00C, 8'h3C);
    chk("drive", 8'hA3, {system_fan_drive, processor_fan_drive});
    xfer(1, 12'h010, 8'h24);
    xfer(1, 12'h014, 8'hC5);
    xfer(1, 12'h018, 8'hB3);
    chk("mode", 4'h9, {processor_fan_mode, system_fan_mode});
    chk("target", 15'h45C5, {system_target_temp, system_target_speed});
    chk("target", 15'h33B3, {processor_target_temp, processor_target_speed});
    xfer(1, 12'h010, 8'h3C);
    chk("mode", 4'h0, {processor_fan_mode, system_fan_mode});
    xfer(1, 12'h94C, 8'h20);
    chk("beep", 1, beep_out);
    xfer(1, 12'h94C, 8'h00);
    chk("beep", 0, beep_out);
    xfer(1, 12'h950, 8'h05);
    xfer(1, 12'h174, 8'h01);
    chk("bat enable", 1, battery_monitor_enable);
    far.conv(8'h80, 8'h33, 9'h040);
    rdchk(6, 8'h00, 8'h25);
    rdchk(5, 8'h51, 8'h33);
    @(posedge aclk) {auxiliary_fan_warn, core_voltage_out, processor_tach_input} <= 3'h7;
    xfer(1, 12'hB54, 8'h90);
    rdchk(4, 8'h50, 8'h05);
    rdchk(4, 8'h5B, 8'h05);
    xfer(1, 12'h94C, 8'h01);
    chk("beep smi", 2'h3, {beep_out, system_mgmt_interrupt_n});
    xfer(1, 12'h944, 8'hFE);
    chk("smi", 0, system_mgmt_interrupt_n);
    xfer(1, 12'hB5C, 8'h40);
    rdchk(4, 8'h50, 8'h07);
    rdchk(4, 8'h5B, 8'h07);
    xfer(1, 12'h94C, 8'h02);
    chk("beep", 1, beep_out);
    for (int i = 0; i < 3; i++) begin
      far.conv(8'h80, 8'h33, i == 0 ? 9'h0F0 : i == 1 ? 9'h056 : 9'h020);
      rdchk(4, 8'h59, i < 2 ? 8'h91 : 8'h81);
    end
    @(posedge aclk) {intrusion_detect, voltage_input_two_out, system_fan_warn} <= 3'h7;
    @(posedge aclk) intrusion_detect <= 0;
    rdchk(4, 8'h5A, 8'h59);
    xfer(1, 12'h940, 8'hFF);
    chk("bresp", 2'h2, rsp);
    xfer(0, 12'h7FC, 0);
    chk("rresp", 2'h2, rsp);
    stop_test;
  end
endmodule // tb_hwm_status_fan_regs
